// >>> rtl/press_contact_sequence_monitor.sv
// Cam contact sequence and ramp-down monitor with an APB register file.
// Notes on behaviour
// - With error flag enabled, an extra output rises on any error.
// - Restart pulse counts only if high between minimum and 30 s.
// - Without restart input, errors hold until the program run stops.
// - Top contact rising must happen while bottom contact is high.
// - Top contact falling must happen while bottom contact is low.
// - Bottom contact rising must happen while top contact is low.
// - Bottom contact falling must happen while top contact is high.
// - Any ordering violation drops release and raises contact error.
// - Optional advance contact falling edge brings top phase forward.
// - Drive-run must rise in top phase or be high when top ends.
// - Startup rises on bottom rising, falls on top rising or advance.
// - Enable low holds release low and pauses monitoring.
// - Top falls on top contact falling, rises on top rise or advance.
`timescale 1ns/10ps
module press_contact_sequence_monitor (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        drive_run,
   input  wire logic        restart_in,
   input  wire logic        top_dead_centre_contact,
   input  wire logic        bottom_dead_centre_contact,
   input  wire logic        advance_contact,
   input  wire logic        enable_in,
   output logic             release_out,
   output logic             top_out,
   output logic             startup_out,
   output logic             restart_required,
   output logic             contact_error,
   output logic             ramp_down_error,
   output logic             error_flag,
   output logic             irq
);
   import press_monitor_pkg::*;

   // ***************************************************************
   // Input sampling
   // ***************************************************************
   logic tdc;
   logic tdc_rise;
   logic tdc_fall;
   logic bdc;
   logic bdc_rise;
   logic bdc_fall;
   logic adv_lvl;
   logic adv_rise_raw;
   logic adv_fall_raw;
   logic run_lvl;
   logic run_rise;
   logic run_fall_unused;
   logic restart_ok;

   // Each contact is compared against its previous sample.
   // The samplers reset low, so a contact resting high shows a false rise
   // on the first edge after reset; the monitor is still in its off state
   // at that edge and ignores every edge.
   edge_sampler u_tdc (.pclk(pclk), .presetn(presetn),
      .din(top_dead_centre_contact), .level(tdc), .rise(tdc_rise),
      .fall(tdc_fall));
   edge_sampler u_bdc (.pclk(pclk), .presetn(presetn),
      .din(bottom_dead_centre_contact), .level(bdc), .rise(bdc_rise),
      .fall(bdc_fall));
   edge_sampler u_adv (.pclk(pclk), .presetn(presetn),
      .din(advance_contact), .level(adv_lvl), .rise(adv_rise_raw),
      .fall(adv_fall_raw));
   edge_sampler u_run (.pclk(pclk), .presetn(presetn),
      .din(drive_run), .level(run_lvl), .rise(run_rise),
      .fall(run_fall_unused));

   // ***************************************************************
   // Register file state
   // ***************************************************************
   logic [4:0]           ctrl_q;
   logic [4:0]           ctrl_d;
   logic [irq_width-1:0] irq_st_q;
   logic [irq_width-1:0] irq_st_d;
   logic [irq_width-1:0] mask_q;
   logic [irq_width-1:0] mask_d;
   logic [31:0]          rdata_q;
   logic [31:0]          rdata_d;

   logic advance_en;
   logic restart_en;
   logic long_min;
   logic flag_en;
   logic prog_run;
   assign advance_en = ctrl_q[ctrl_advance_en_bit];
   assign restart_en = ctrl_q[ctrl_restart_en_bit];
   assign long_min   = ctrl_q[ctrl_long_min_bit];
   assign flag_en    = ctrl_q[ctrl_err_flag_en_bit];
   assign prog_run   = ctrl_q[ctrl_run_bit];

   // Restart pulse measured by a clock-derived counter.
   restart_pulse_checker u_restart (.pclk(pclk), .presetn(presetn),
      .restart_in(restart_in & restart_en), .long_min(long_min),
      .valid_pulse(restart_ok));

   // ***************************************************************
   // Sequence monitor
   // ***************************************************************
   mon_state_t state_q;
   mon_state_t state_d;
   logic       top_q;
   logic       top_d;
   logic       startup_q;
   logic       startup_d;
   logic       cerr_q;
   logic       cerr_d;
   logic       rerr_q;
   logic       rerr_d;
   logic       run_seen_q;
   logic       run_seen_d;
   logic       adv_fall;
   logic       viol;
   logic       ramp_fail;
   logic       clear_err;
   logic       active;

   assign adv_fall = advance_en & adv_fall_raw;

   // Any edge that breaks the ordering conditions.
   assign viol = (tdc_rise & ~bdc)
               | (tdc_fall & bdc)
               | (bdc_rise & tdc)
               | (bdc_fall & ~tdc);

   // Top phase ends without a drive-run rise and with drive-run low.
   assign ramp_fail = top_q & tdc_fall & ~bdc & ~run_seen_q & ~run_rise
                    & ~run_lvl;

   // Errors clear by a valid pulse or, without restart, a run cycle.
   assign clear_err = restart_en ? restart_ok : ~prog_run;

   assign active = (state_q == st_run) || (state_q == st_idle);

   // Next-state logic for the monitor.
   always_comb begin
      state_d    = state_q;
      top_d      = top_q;
      startup_d  = startup_q;
      cerr_d     = cerr_q;
      rerr_d     = rerr_q;
      run_seen_d = run_seen_q;
      case (state_q)
         st_off: begin
            if (prog_run) begin
               state_d   = st_idle;
               top_d     = tdc;
               startup_d = 1'b0;
            end
         end
         st_idle, st_run: begin
            if (!prog_run) begin
               state_d = st_off;
            end else if (!enable_in) begin
               state_d = st_idle;
            end else if (viol) begin
               state_d   = st_error;
               cerr_d    = 1'b1;
               top_d     = 1'b0;
               startup_d = 1'b0;
            end else if (ramp_fail) begin
               state_d   = st_error;
               rerr_d    = 1'b1;
               top_d     = 1'b0;
               startup_d = 1'b0;
            end else begin
               state_d = st_run;
               if (state_q == st_idle) begin
                  top_d = tdc; // Resume in the state the contacts show.
               end
               if (run_rise && top_q) begin
                  run_seen_d = 1'b1;
               end
               if (tdc_fall) begin
                  top_d      = 1'b0;
                  run_seen_d = 1'b0;
               end else if (tdc_rise || adv_fall) begin
                  top_d = 1'b1;
               end
               if (bdc_rise) begin
                  startup_d = 1'b1;
                  if (top_q) begin
                     top_d = 1'b0;
                  end
               end else if (tdc_rise || adv_fall) begin
                  startup_d = 1'b0;
               end
            end
         end
         st_error: begin
            if (clear_err) begin
               state_d = restart_en ? st_idle : st_off;
               cerr_d  = 1'b0;
               rerr_d  = 1'b0;
               top_d   = tdc;
            end
         end
         default: begin
            state_d = st_off;
         end
      endcase
   end

   // Monitor registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= st_off;
         top_q      <= 1'b0;
         startup_q  <= 1'b0;
         cerr_q     <= 1'b0;
         rerr_q     <= 1'b0;
         run_seen_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         top_q      <= top_d;
         startup_q  <= startup_d;
         cerr_q     <= cerr_d;
         rerr_q     <= rerr_d;
         run_seen_q <= run_seen_d;
      end
   end

   // Outputs follow the monitor state.
   assign release_out      = active & enable_in & ~cerr_q & ~rerr_q;
   assign top_out          = top_q;
   assign startup_out      = startup_q;
   assign contact_error    = cerr_q;
   assign ramp_down_error  = rerr_q;
   assign restart_required = cerr_q | rerr_q;
   assign error_flag       = flag_en & (cerr_q | rerr_q);

   // ***************************************************************
   // APB slave
   // ***************************************************************
   logic                 wr_acc;
   logic                 rd_acc;
   logic [irq_width-1:0] events;
   logic [6:0]           status_vec;

   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign events = {(state_q == st_error) & clear_err,
                    rerr_d & ~rerr_q, cerr_d & ~cerr_q};
   assign status_vec = {error_flag, rerr_q, cerr_q, restart_required,
                        startup_q, top_q, release_out};

   // Register writes, sticky events and read data.
   always_comb begin
      ctrl_d   = ctrl_q;
      mask_d   = mask_q;
      irq_st_d = irq_st_q;
      rdata_d  = rdata_q;
      if (rd_acc && paddr == irq_offset) begin
         irq_st_d = '0; // Read clears; a new event below still wins.
      end
      irq_st_d = irq_st_d | events;
      if (wr_acc) begin
         case (paddr)
            ctrl_offset: ctrl_d = pwdata[4:0];
            mask_offset: mask_d = pwdata[irq_width-1:0];
            default: ;
         endcase
      end
      if (rd_acc) begin
         case (paddr)
            ctrl_offset:  rdata_d = {27'h0, ctrl_q};
            state_offset: rdata_d = {21'h0, state_q, status_vec};
            irq_offset:   rdata_d = {29'h0, irq_st_q};
            mask_offset:  rdata_d = {29'h0, mask_q};
            default:      rdata_d = 32'h0;
         endcase
      end
   end

   // Register file flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q   <= ctrl_reset_value;
         mask_q   <= '0;
         irq_st_q <= '0;
         rdata_q  <= 32'h0;
      end else begin
         ctrl_q   <= ctrl_d;
         mask_q   <= mask_d;
         irq_st_q <= irq_st_d;
         rdata_q  <= rdata_d;
      end
   end

   // Zero wait state; unmapped addresses answer an error.
   assign pready  = 1'b1;
   assign pslverr = psel & penable & (paddr != ctrl_offset)
                  & (paddr != state_offset) & (paddr != irq_offset)
                  & (paddr != mask_offset);
   assign prdata  = rd_acc ? (paddr == ctrl_offset ? {27'h0, ctrl_q} :
                    paddr == state_offset ? {21'h0, state_q, status_vec} :
                    paddr == irq_offset ? {29'h0, irq_st_q} :
                    paddr == mask_offset ? {29'h0, mask_q} : 32'h0)
                    : rdata_q;
   assign irq     = |(irq_st_q & mask_q);

endmodule // press_contact_sequence_monitor

// >>> rtl/press_monitor_pkg.sv
// Package with register map, field positions and timing constants.
package press_monitor_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [11:0] ctrl_offset   = 12'h000;
   localparam logic [11:0] state_offset  = 12'h004;
   localparam logic [11:0] irq_offset    = 12'h008;
   localparam logic [11:0] mask_offset   = 12'h00c;

   // Control register fields.
   localparam int ctrl_advance_en_bit  = 0;
   localparam int ctrl_restart_en_bit  = 1;
   localparam int ctrl_long_min_bit    = 2;
   localparam int ctrl_err_flag_en_bit = 3;
   localparam int ctrl_run_bit         = 4;
   localparam logic [4:0] ctrl_reset_value = 5'h12;

   // Status register fields.
   localparam int st_release_bit  = 0;
   localparam int st_top_bit      = 1;
   localparam int st_startup_bit  = 2;
   localparam int st_restart_bit  = 3;
   localparam int st_contact_bit  = 4;
   localparam int st_ramp_bit     = 5;
   localparam int st_flag_bit     = 6;

   // Interrupt status fields.
   localparam int irq_contact_bit = 0;
   localparam int irq_ramp_bit    = 1;
   localparam int irq_cleared_bit = 2;
   localparam int irq_width       = 3;

   // ***************************************************************
   // Restart pulse timing
   // ***************************************************************
   localparam int clk_hz          = 100_000_000;
   localparam int min_short_ms    = 100;
   localparam int min_long_ms     = 350;
   localparam int max_pulse_s     = 30;
   localparam int min_short_cyc   = min_short_ms * (clk_hz / 1000);
   localparam int min_long_cyc    = min_long_ms * (clk_hz / 1000);
   localparam longint max_cyc_l   = longint'(max_pulse_s) * clk_hz;
   // Kept unsigned: three billion cycles does not fit in an int.
   localparam logic [31:0] max_pulse_cyc = max_cyc_l[31:0];
   localparam int pulse_cnt_width = 32;

   // Sequence states, one-hot.
   typedef enum logic [3:0] {
      st_idle  = 4'h1,
      st_run   = 4'h2,
      st_error = 4'h4,
      st_off   = 4'h8
   } mon_state_t;

endpackage

// >>> rtl/edge_sampler.sv
// Input sample register with rising and falling edge detection.
`timescale 1ns/10ps
module edge_sampler (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic prev_q;
   logic prev_d;

   // Next sample is the current input.
   always_comb begin
      prev_d = din;
   end

   // Previous sample register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   // Edges compare the input against the previous sample.
   assign level = din;
   assign rise  = din & ~prev_q;
   assign fall  = ~din & prev_q;

endmodule // edge_sampler

// >>> rtl/restart_pulse_checker.sv
// Restart pulse width checker for low-high-low pulses.
`timescale 1ns/10ps
module restart_pulse_checker (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic restart_in,
   input  wire logic long_min,
   output logic      valid_pulse
);
   import press_monitor_pkg::*;

   logic [pulse_cnt_width-1:0] cnt_q;
   logic [pulse_cnt_width-1:0] cnt_d;
   logic                       hi_q;
   logic                       hi_d;
   logic                       valid_q;
   logic                       valid_d;
   logic [pulse_cnt_width-1:0] min_cyc;

   assign min_cyc = long_min ? pulse_cnt_width'(min_long_cyc)
                             : pulse_cnt_width'(min_short_cyc);

   // Count high time; judge width on the falling edge.
   always_comb begin
      cnt_d   = cnt_q;
      hi_d    = restart_in;
      valid_d = 1'b0;
      if (restart_in) begin
         if (cnt_q != pulse_cnt_width'(max_pulse_cyc) + 1'b1) begin
            cnt_d = cnt_q + 1'b1;
         end
      end else begin
         if (hi_q && cnt_q >= min_cyc
             && cnt_q <= pulse_cnt_width'(max_pulse_cyc)) begin
            valid_d = 1'b1;
         end
         cnt_d = '0;
      end
   end

   // Counter and pulse registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q   <= '0;
         hi_q    <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         hi_q    <= hi_d;
         valid_q <= valid_d;
      end
   end

   assign valid_pulse = valid_q;

endmodule // restart_pulse_checker

// >>> tb/press_chk.sv
// Concurrent checks on the press contact sequence monitor ports.
`timescale 1ns/10ps
module press_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic top_dead_centre_contact,
   input wire logic bottom_dead_centre_contact,
   input wire logic enable_in,
   input wire logic release_out,
   input wire logic top_out,
   input wire logic startup_out,
   input wire logic contact_error,
   input wire logic ramp_down_error,
   input wire logic error_flag
);
   // *****************
   // Contact checks
   // *****************
   // Short names for the two cam contacts.
   wire logic tdc = top_dead_centre_contact;
   wire logic bdc = bottom_dead_centre_contact;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Contact edges seen while the press is released.
   sequence s_tdc_up; $rose(tdc) && !bdc && release_out; endsequence
   sequence s_tdc_dn; $fell(tdc) && bdc && release_out; endsequence
   sequence s_bdc_up; $rose(bdc) && tdc && release_out; endsequence
   sequence s_bdc_dn; $fell(bdc) && !tdc && release_out; endsequence
   sequence s_bdc_ok; $rose(bdc) && !tdc && release_out; endsequence

   // Each bad edge raises the contact error one cycle later.
   property p_tdc_up; s_tdc_up |=> contact_error; endproperty
   property p_tdc_dn; s_tdc_dn |=> contact_error; endproperty
   property p_bdc_up; s_bdc_up |=> contact_error; endproperty
   property p_bdc_dn; s_bdc_dn |=> contact_error; endproperty
   property p_err_out;
      contact_error |-> !release_out && !top_out && !startup_out;
   endproperty
   property p_flag; error_flag |-> contact_error || ramp_down_error;
   endproperty
   property p_enable; !enable_in |-> !release_out; endproperty
   property p_top; $fell(tdc) && release_out |=> !top_out; endproperty
   property p_startup; s_bdc_ok |=> startup_out; endproperty

   a_tdc_up: assert property (p_tdc_up)
      else $error("top rise with bottom low not flagged");
   a_tdc_dn: assert property (p_tdc_dn)
      else $error("top fall with bottom high not flagged");
   a_bdc_up: assert property (p_bdc_up)
      else $error("bottom rise with top high not flagged");
   a_bdc_dn: assert property (p_bdc_dn)
      else $error("bottom fall with top low not flagged");
   a_err_out: assert property (p_err_out)
      else $error("outputs active during contact error");
   a_flag: assert property (p_flag)
      else $error("error flag without an error");
   a_enable: assert property (p_enable)
      else $error("release high while enable is low");
   a_top: assert property (p_top)
      else $error("top stayed high after top contact fell");
   a_startup: assert property (p_startup)
      else $error("startup missed on bottom rise");
endmodule // press_chk

bind press_contact_sequence_monitor press_chk i_press_chk (
   .pclk, .presetn, .top_dead_centre_contact, .bottom_dead_centre_contact,
   .enable_in, .release_out, .top_out, .startup_out, .contact_error,
   .ramp_down_error, .error_flag);

// >>> tb/press_cam_model.sv
// Behavioural model of the cam contacts and the drive command.
`timescale 1ns/10ps
module press_cam_model (
   input  wire logic pclk,
   output logic      top_dead_centre_contact,
   output logic      bottom_dead_centre_contact,
   output logic      drive_run,
   output logic      advance_contact
);
   // *****************
   // Cam stimulus
   // *****************
   // The press rests at the top with the drive commanded on.
   initial begin
      top_dead_centre_contact    = 1'h1;
      bottom_dead_centre_contact = 1'h0;
      drive_run                  = 1'h1;
      advance_contact            = 1'h1;
   end

   // Sets top, bottom and drive, then lets the cams dwell.
   task automatic move(input logic [2:0] s);
      @(posedge pclk);
      top_dead_centre_contact    <= s[2];
      bottom_dead_centre_contact <= s[1];
      drive_run                  <= s[0];
      repeat (8) @(posedge pclk);
   endtask

   // Gives the advance contact one short low pulse.
   task automatic advance();
      @(posedge pclk);
      advance_contact <= 1'h0;
      repeat (4) @(posedge pclk);
      advance_contact <= 1'h1;
      repeat (4) @(posedge pclk);
   endtask
endmodule // press_cam_model

// >>> tb/tb_top.sv
// Self-checking bench for the press contact sequence monitor.
`timescale 1ns/10ps
module tb_top;
   import press_monitor_pkg::*;
   // *****************
   // Bench plumbing
   // *****************
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic        restart_in, enable_in, drive_run, advance_contact;
   logic        top_dead_centre_contact, bottom_dead_centre_contact;
   logic        release_out, top_out, startup_out, restart_required;
   logic        contact_error, ramp_down_error, error_flag, irq;
   int          errors = 0;
   int          n_compared = 0;
   int          cyc = 0;

   press_contact_sequence_monitor i_press_contact_sequence_monitor (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .drive_run, .restart_in, .top_dead_centre_contact,
      .bottom_dead_centre_contact, .advance_contact, .enable_in,
      .release_out, .top_out, .startup_out, .restart_required,
      .contact_error, .ramp_down_error, .error_flag, .irq);
   press_cam_model i_press_cam_model (
      .pclk, .top_dead_centre_contact, .bottom_dead_centre_contact,
      .drive_run, .advance_contact);

   // Free-running clock at 100 MHz.
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end

   // Cuts a hung run short.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Compares one value, taken at the call, and counts the comparison.
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the answer is taken at the pready edge.
   task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) begin
         @(posedge pclk);
      end
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic cam(logic [2:0] s);
      i_press_cam_model.move(s);
   endtask

   // *****************
   // Scenarios
   // *****************
   // Reset values, a refused address and the status in the run state at rest.
   task automatic t_regs();
      apb(1'h0, ctrl_offset, 32'h0);
      chk("ctrl", {27'h0, ctrl_reset_value}, rdata);
      apb(1'h0, 12'h010, 32'h0);
      chk("unmapped err", 1'h1, err);
      chk("unmapped data", 32'h0, rdata);
      apb(1'h0, state_offset, 32'h0);
      chk("status", 32'h103, rdata);
      chk("irq", 1'h0, irq);
   endtask

   // A clean stroke, then enable dropped on a healthy press.
   task automatic t_stroke();
      cam(3'h1);
      chk("top", 1'h0, top_out);
      cam(3'h3);
      chk("startup", 1'h1, startup_out);
      cam(3'h7);
      chk("top", 1'h1, top_out);
      chk("startup", 1'h0, startup_out);
      cam(3'h5);
      chk("errors", 1'h0, restart_required);
      @(posedge pclk);
      enable_in <= 1'h0;
      repeat (2) @(posedge pclk);
      chk("release", 1'h0, release_out);
      @(posedge pclk);
      enable_in <= 1'h1;
      repeat (2) @(posedge pclk);
      chk("release", 1'h1, release_out);
   endtask

   // The advance contact ends startup early on the upstroke.
   task automatic t_advance();
      apb(1'h1, ctrl_offset, 32'h13);
      cam(3'h1);
      cam(3'h3);
      i_press_cam_model.advance();
      chk("top", 1'h1, top_out);
      chk("startup", 1'h0, startup_out);
      cam(3'h7);
      cam(3'h5);
      chk("errors", 1'h0, restart_required);
   endtask

   // Contact error, its interrupt, a short restart and a stop/run clear.
   task automatic t_contact();
      apb(1'h1, ctrl_offset, 32'h1a);
      apb(1'h1, mask_offset, 32'h7);
      cam(3'h7);
      chk("contact", 1'h1, contact_error);
      chk("release", 1'h0, release_out);
      chk("flag", 1'h1, error_flag);
      chk("irq", 1'h1, irq);
      apb(1'h0, irq_offset, 32'h0);
      chk("irq status", 32'h1, rdata);
      @(posedge pclk);
      chk("irq", 1'h0, irq);
      @(posedge pclk);
      restart_in <= 1'h1;
      repeat (200) @(posedge pclk);
      restart_in <= 1'h0;
      repeat (4) @(posedge pclk);
      chk("short restart", 1'h1, contact_error);
      @(posedge pclk);
      enable_in <= 1'h0;
      repeat (2) @(posedge pclk);
      chk("held", 1'h1, restart_required);
      @(posedge pclk);
      enable_in <= 1'h1;
      apb(1'h1, ctrl_offset, 32'h08);
      repeat (2) @(posedge pclk);
      chk("stopped", 1'h0, restart_required);
      apb(1'h1, ctrl_offset, 32'h18);
      apb(1'h0, irq_offset, 32'h0);
      chk("cleared", 32'h4, rdata);
      cam(3'h5);
   endtask

   // Ramp-down fault with the drive off, masked and then unmasked.
   task automatic t_ramp();
      apb(1'h1, mask_offset, 32'h0);
      cam(3'h4);
      cam(3'h0);
      chk("ramp", 1'h1, ramp_down_error);
      chk("release", 1'h0, release_out);
      chk("restart req", 1'h1, restart_required);
      chk("masked irq", 1'h0, irq);
      apb(1'h1, mask_offset, 32'h2);
      @(posedge pclk);
      chk("irq", 1'h1, irq);
      apb(1'h0, irq_offset, 32'h0);
      chk("irq status", 32'h2, rdata);
   endtask

   // Each bad contact edge from a fresh run start.
   task automatic t_order();
      logic [1:0] start_pos [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
      logic [1:0] bad_pos [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, ctrl_offset, 32'h08);
         cam({start_pos[i], 1'h1});
         apb(1'h1, ctrl_offset, 32'h18);
         repeat (2) @(posedge pclk);
         cam({bad_pos[i], 1'h1});
         chk("order", 1'h1, contact_error);
      end
   endtask

   // Resets the block and runs every scenario in turn.
   initial begin
      presetn    = 1'h0;
      psel       = 1'h0;
      penable    = 1'h0;
      pwrite     = 1'h0;
      paddr      = 12'h000;
      pwdata     = 32'h0;
      restart_in = 1'h0;
      enable_in  = 1'h1;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      repeat (2) @(posedge pclk);
      t_regs();
      t_stroke();
      t_advance();
      t_contact();
      t_ramp();
      t_order();
      tally_and_finish();
   end
endmodule // tb_top
